// [shared/ca_decode_pkg.sv]
package ca_decode_pkg;
    // Pin group widths
    localparam int ADDR_W      = 17;   // A0..A16, A17 never used as address
    localparam int BA_W        = 2;
    localparam int BG_W        = 2;    // x8 width; x16 uses bit 0 only
    localparam int ROW_W       = 17;
    localparam int COL_W       = 10;
    localparam int OP_W        = 14;
    // Address bit positions with extra meaning
    localparam int AP_BIT      = 10;
    localparam int BC_BIT      = 12;
    // Sampled command bits {cs_n, ras_n, cas_n, we_n}, act_n high
    localparam logic [3:0] CODE_MRS = 4'h0;
    localparam logic [3:0] CODE_REF = 4'h1;
    localparam logic [3:0] CODE_PRE = 4'h2;
    localparam logic [3:0] CODE_RD  = 4'h5;
    localparam logic [3:0] CODE_WR  = 4'h4;
    localparam logic [3:0] CODE_ZQC = 4'h6;
    localparam logic [3:0] CODE_NOP = 4'h7;
    // Reset values
    localparam logic       CKE_RST   = 1'b0;
    localparam logic [1:0] LINK_RST  = 2'h0;

    // Decoded command kinds
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_ACT  = 4'h1,
        CMD_RD   = 4'h2,
        CMD_WR   = 4'h3,
        CMD_PRE  = 4'h4,
        CMD_REF  = 4'h5,
        CMD_MRS  = 4'h6,
        CMD_ZQC  = 4'h7,
        CMD_NOP  = 4'h8
    } cmd_t;

    // Power modes, Gray coded along run -> power-down -> self refresh
    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_PPD = 2'b01,
        PM_APD = 2'b11,
        PM_SR  = 2'b10
    } pm_t;
endpackage

// [hw/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Two flop synchroniser for a group of pin levels
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin,
    output var  logic [W-1:0] level
);
    logic [W-1:0] meta;   // First stage, read only by the second

    // Metastability settles in the first stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta  <= '0;
            level <= '0;
        end else begin
            meta  <= pin;
            level <= meta;
        end
    end
endmodule
`default_nettype wire

// [hw/bank_table.sv]
`timescale 1ns/1ps
`default_nettype none
// Open-row flag per bank, registered summary output
module bank_table (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       open_en,
    input  wire logic       close_en,
    input  wire logic       close_all,
    input  wire logic [3:0] bank,
    output var  logic       any_open
);
    logic [15:0] open_row;     // One flag per bank
    logic [15:0] next_open;

    // Opening and closing in one step; open wins for same bank
    always_comb begin
        next_open = open_row;
        if (close_all) begin
            next_open = '0;
        end else if (close_en) begin
            next_open[bank] = 1'b0;
        end
        if (open_en) begin
            next_open[bank] = 1'b1;
        end
    end

    // Flags and summary registered
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            open_row <= '0;
            any_open <= 1'b0;
        end else begin
            open_row <= next_open;
            any_open <= |next_open;
        end
    end
endmodule
`default_nettype wire

// [hw/sdram_cmd_addr_input_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_addr_input_decode (
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    input  wire logic                              ck_t,
    input  wire logic                              ck_c,
    input  wire logic                              cke,
    input  wire logic                              cs_n,
    input  wire logic                              act_n,
    input  wire logic                              ras_n,
    input  wire logic                              cas_n,
    input  wire logic                              we_n,
    input  wire logic [ca_decode_pkg::ADDR_W-1:0]  addr,
    input  wire logic                              addr17,
    input  wire logic [ca_decode_pkg::BA_W-1:0]    ba,
    input  wire logic [ca_decode_pkg::BG_W-1:0]    bg,
    input  wire logic                              odt,
    input  wire logic                              x16_mode,
    input  wire logic                              rtt_nom_en,
    input  wire logic                              self_refresh_req,
    output var  logic                              cmd_valid,
    output var  ca_decode_pkg::cmd_t               cmd,
    output var  logic [ca_decode_pkg::BA_W-1:0]    cmd_bank,
    output var  logic [ca_decode_pkg::BG_W-1:0]    cmd_group,
    output var  logic [ca_decode_pkg::ROW_W-1:0]   row_addr,
    output var  logic [ca_decode_pkg::COL_W-1:0]   col_addr,
    output var  logic [ca_decode_pkg::OP_W-1:0]    mrs_opcode,
    output var  logic [3:0]                        mrs_select,
    output var  logic                              auto_precharge,
    output var  logic                              precharge_all,
    output var  logic                              burst_full,
    output var  logic                              clk_active,
    output var  logic                              ca_buf_en,
    output var  logic                              ctl_buf_en,
    output var  logic                              out_drv_en,
    output var  ca_decode_pkg::pm_t                power_mode,
    output var  logic                              rtt_nom_on,
    output var  logic                              rtt_dqs_upper_on,
    output var  logic                              rtt_dm_upper_on
);
    import ca_decode_pkg::*;

    // Synchronised pin bundle: ck_t, ck_c, cke, odt, cs, act, ras, cas, we, ba, bg, addr
    localparam int SW = 9 + BA_W + BG_W + ADDR_W;

    logic [SW-1:0] pins_s;        // All pins except addr17 after two flops
    logic          ck_t_s;        // True clock level
    logic          ck_c_s;        // Complement clock level
    logic          cke_s;         // Clock enable level
    logic          odt_s;         // Termination control level
    logic          cs_s;
    logic          act_s;
    logic          ras_s;
    logic          cas_s;
    logic          we_s;
    logic [BA_W-1:0]   ba_s;
    logic [BG_W-1:0]   bg_s;
    logic [ADDR_W-1:0] addr_s;
    logic          ck_t_d;        // Previous true clock level
    logic          ck_c_d;        // Previous complement level
    logic          any_open;      // Row open in some bank
    logic          cke_async;     // Raw CKE latched without clock
    logic          cke_exit;      // Synchronised asynchronous wake

    // Every pin level passes two flops before any decode reads it.
    // The link clock is sampled like the rest, so it must stay at
    // least four system clocks per period for edges to be seen.
    // addr17 is accepted at the pin but never read as address
    pin_sync #(.W(SW)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     ({ck_t, ck_c, cke, odt, cs_n, act_n, ras_n, cas_n, we_n, ba, bg, addr}),
        .level   (pins_s)
    );

    assign {ck_t_s, ck_c_s, cke_s, odt_s, cs_s, act_s, ras_s, cas_s, we_s,
            ba_s, bg_s, addr_s} = pins_s;

    // Crossing point: true rises while complement falls
    wire ck_edge = ck_t_s & ~ck_t_d & ~ck_c_s & ck_c_d;

    // Clock edges only count while the clock buffer is live
    wire edge_ok = ck_edge & clk_active;

    // Command code, chip select being its top bit
    wire [3:0] code   = {cs_s, ras_s, cas_s, we_s};
    wire       sel    = ~cs_s;
    wire       is_act = sel & ~act_s;

    // Group width depends on part organisation
    wire [BG_W-1:0] grp = x16_mode ? {1'b0, bg_s[0]} : bg_s;

    // Decode non-activate commands from command pins
    function automatic cmd_t decode(input logic [3:0] c);
        case (c)
            CODE_MRS: decode = CMD_MRS;
            CODE_REF: decode = CMD_REF;
            CODE_PRE: decode = CMD_PRE;
            CODE_RD:  decode = CMD_RD;
            CODE_WR:  decode = CMD_WR;
            CODE_ZQC: decode = CMD_ZQC;
            CODE_NOP: decode = CMD_NOP;
            default:  decode = CMD_NONE;
        endcase
    endfunction

    // Final command: masked when deselected, activate overrides
    wire cmd_t dec_cmd = !sel ? CMD_NONE :
                         is_act ? CMD_ACT :
                         decode(code);

    wire is_rw  = (dec_cmd == CMD_RD) || (dec_cmd == CMD_WR);
    wire is_pre = (dec_cmd == CMD_PRE);

    // Bank index for the open-row table
    wire [3:0] bank_idx = {grp, ba_s};

    // Row address: A16..A14 come from command pins on activate
    // Pin levels are taken as they stand; the active-low sense only
    // applies when the same pins carry a command code.
    wire [ROW_W-1:0] row_w = {ras_s, cas_s, we_s, addr_s[13:0]};

    // Last clock levels, for edge finding
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ck_t_d <= 1'b0;
            ck_c_d <= 1'b1;
        end else begin
            ck_t_d <= ck_t_s;
            ck_c_d <= ck_c_s;
        end
    end

    // Open rows per bank; auto precharge closes on the access
    bank_table u_banks (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .open_en   (edge_ok & (dec_cmd == CMD_ACT)),
        .close_en  (edge_ok & ((is_pre & ~addr_s[AP_BIT]) | (is_rw & addr_s[AP_BIT]))),
        .close_all (edge_ok & is_pre & addr_s[AP_BIT]),
        .bank      (bank_idx),
        .any_open  (any_open)
    );

    // Latch is held clear outside self refresh, so only a rise of CKE
    // while in self refresh can wake us. A flag left set from an
    // earlier power-down exit would make the catch meaningless.
    // The clear is decoded from both power_mode bits, which change together between PM_RUN and PM_APD.
    wire wake_clr = rst | (power_mode != PM_SR);

    // CKE rising caught with no clock, armed only in self refresh
    always_ff @(posedge cke or posedge wake_clr) begin
        if (wake_clr) begin
            cke_async <= 1'b0;
        end else begin
            cke_async <= 1'b1;
        end
    end

    // Wake flag enters the clock domain through two flops
    pin_sync #(.W(1)) u_wake (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     (cke_async & (power_mode == PM_SR)),
        .level   (cke_exit)
    );

    // Power state next value
    pm_t next_mode;
    always_comb begin
        next_mode = power_mode;
        case (power_mode)
            PM_RUN: begin
                // Controller keeps CKE high over any access
                if (edge_ok && !cke_s) begin
                    if (any_open) begin
                        next_mode = PM_APD;
                    end else if (self_refresh_req) begin
                        next_mode = PM_SR;
                    end else begin
                        next_mode = PM_PPD;
                    end
                end
            end
            PM_PPD, PM_APD: begin
                // Clock still running, so exit is seen on an edge
                if (edge_ok && cke_s) begin
                    next_mode = PM_RUN;
                end
            end
            PM_SR: begin
                // No clock edges here; the async catch wakes us
                if (cke_exit && cke_s) begin
                    next_mode = PM_RUN;
                end
            end
            default: next_mode = PM_RUN;
        endcase
    end

    // Buffer enables follow the next power state
    wire next_run = (next_mode == PM_RUN);
    wire next_sr  = (next_mode == PM_SR);

    // Termination follows ODT only when nominal termination is on
    wire next_rtt = ~next_sr & rtt_nom_en & odt_s;

    // Power state and buffer enables; CKE buffer itself is never gated
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            power_mode <= PM_RUN;
            clk_active <= CKE_RST;
            ca_buf_en  <= CKE_RST;
            ctl_buf_en <= CKE_RST;
            out_drv_en <= CKE_RST;
        end else begin
            power_mode <= next_mode;
            clk_active <= ~next_sr;
            ca_buf_en  <= next_run;
            ctl_buf_en <= ~next_sr;
            out_drv_en <= next_run;
        end
    end

    // Nominal termination on data, strobe and mask pins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rtt_nom_on       <= 1'b0;
            rtt_dqs_upper_on <= 1'b0;
            rtt_dm_upper_on  <= 1'b0;
        end else if (edge_ok | next_sr) begin
            rtt_nom_on       <= next_rtt;
            rtt_dqs_upper_on <= next_rtt & x16_mode;
            rtt_dm_upper_on  <= next_rtt & x16_mode;
        end
    end

    // Command strobe: one cycle, only on a live edge in run mode.
    // Commands that arrive in power-down are dropped, not queued:
    // the controller is expected not to send any there.
    wire take = edge_ok & (power_mode == PM_RUN) & cke_s & (dec_cmd != CMD_NONE);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= take;
        end
    end

    // Command fields held until the next accepted command
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmd            <= CMD_NONE;
            cmd_bank       <= LINK_RST;
            cmd_group      <= LINK_RST;
            row_addr       <= '0;
            col_addr       <= '0;
            mrs_opcode     <= '0;
            mrs_select     <= '0;
            auto_precharge <= 1'b0;
            precharge_all  <= 1'b0;
            burst_full     <= 1'b0;
        end else if (take) begin
            cmd            <= dec_cmd;
            cmd_bank       <= ba_s;
            cmd_group      <= grp;
            row_addr       <= is_act ? row_w : '0;
            col_addr       <= is_rw ? addr_s[COL_W-1:0] : '0;
            mrs_opcode     <= addr_s[OP_W-1:0];
            mrs_select     <= {1'b0, bg_s[0], ba_s};
            auto_precharge <= is_rw & addr_s[AP_BIT];
            precharge_all  <= is_pre & addr_s[AP_BIT];
            burst_full     <= is_rw & addr_s[BC_BIT];
        end
    end
endmodule
`default_nettype wire

// [tb/sdram_cmd_addr_input_decode_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// Port level checks beside the command decoder
module ca_decode_checker (
    input wire logic                sys_clk,
    input wire logic                rst,
    input wire logic                cs_n,
    input wire logic                act_n,
    input wire logic                ras_n,
    input wire logic                cas_n,
    input wire logic                we_n,
    input wire logic [16:0]         addr,
    input wire logic [1:0]          ba,
    input wire logic [1:0]          bg,
    input wire logic                x16_mode,
    input wire logic                cmd_valid,
    input wire ca_decode_pkg::cmd_t cmd,
    input wire logic [1:0]          cmd_bank,
    input wire logic [1:0]          cmd_group,
    input wire logic [16:0]         row_addr,
    input wire logic [3:0]          mrs_select,
    input wire logic                auto_precharge,
    input wire logic                precharge_all,
    input wire logic                burst_full,
    input wire logic                clk_active,
    input wire logic                ca_buf_en,
    input wire logic                ctl_buf_en,
    input wire logic                out_drv_en,
    input wire ca_decode_pkg::pm_t  power_mode
);
    import ca_decode_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Pins three cycles before a pulse are still the taken command
    pulse_once_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("pulse too long");
    cs_mask_a: assert property (cmd_valid |-> !$past(cs_n, 3))
        else $error("deselected command taken");
    act_row_a: assert property (cmd_valid && !$past(act_n, 3)
        |-> cmd == CMD_ACT && row_addr == $past({ras_n, cas_n, we_n, addr[13:0]}, 3))
        else $error("activate row wrong");
    ap_bc_a: assert property (cmd_valid && cmd inside {CMD_RD, CMD_WR}
        |-> auto_precharge == $past(addr[AP_BIT], 3) && burst_full == $past(addr[BC_BIT], 3))
        else $error("access qualifier wrong");
    pre_all_a: assert property (cmd_valid && cmd == CMD_PRE
        |-> precharge_all == $past(addr[AP_BIT], 3))
        else $error("precharge scope wrong");
    bank_sel_a: assert property (cmd_valid && cmd inside {CMD_ACT, CMD_RD, CMD_WR, CMD_PRE}
        |-> cmd_bank == $past(ba, 3))
        else $error("bank wrong");
    mrs_sel_a: assert property (cmd_valid && cmd == CMD_MRS
        |-> mrs_select == {1'b0, $past(bg[0], 3), $past(ba, 3)})
        else $error("mode register select wrong");
    x16_group_a: assert property (cmd_valid && x16_mode |-> !cmd_group[1])
        else $error("upper group bit used");
    pd_buf_a: assert property (power_mode != PM_RUN |-> !ca_buf_en && !out_drv_en)
        else $error("buffers on in power-down");
    sr_buf_a: assert property (power_mode == PM_SR |-> !clk_active && !ctl_buf_en)
        else $error("clock on in self refresh");
endmodule
bind sdram_cmd_addr_input_decode ca_decode_checker i_ca_decode_checker (.*);
`default_nettype wire

// [tb/ddr_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Memory controller model driving the command pins
module ddr_ctrl_model (
    output var logic        ck_t,
    output var logic        ck_c,
    output var logic        cke,
    output var logic        cs_n,
    output var logic        act_n,
    output var logic        ras_n,
    output var logic        cas_n,
    output var logic        we_n,
    output var logic [16:0] addr,
    output var logic        addr17,
    output var logic [1:0]  ba,
    output var logic [1:0]  bg,
    output var logic        odt
);
    logic run = 1'b1;   // Link clock gate
    logic cke_v = 1'b1; // Clock enable for next edge
    logic odt_v = 1'b0; // Termination request for next edge
    // Complement wire of the pair
    assign ck_c = ~ck_t;
    // Link clock, phase offset from sys_clk
    initial begin
        {ck_t, cke, cs_n, act_n, ras_n, cas_n, we_n, odt} = 8'h7e;
        {addr, addr17, bg, ba} = {17'h1c000, 5'h00};
        #3;
        forever begin
            #32;
            if (run) ck_t = ~ck_t;
        end
    end
    // Change on falling link edge, held over the rising one
    task automatic send(input logic c, a, input logic [2:0] k, input logic [16:0] ad, input logic [3:0] bb);
        @(negedge ck_t);
        cke = cke_v;                        // Lowered only between accesses
        odt = odt_v;
        cs_n = c;
        act_n = a;
        addr = c ? ~addr : {k, ad[13:0]};   // Deselected: no stale value
        {ras_n, cas_n, we_n} = addr[16:14]; // Same wires as row bits
        {bg, ba} = c ? ~{bg, ba} : bb;
        addr17 = ~addr17;                   // Noise on the unused bit
        @(posedge ck_t);
    endtask
    // Self refresh exit with the link clock stopped
    task automatic wake();
        run = 1'b0;
        #100;
        cke = 1'b1;
        cke_v = 1'b1;
    endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
// Self-checking bench for the command decoder
module tb;
    import ca_decode_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic x16_mode = 1'b0;
    logic rtt_nom_en = 1'b0;
    logic self_refresh_req = 1'b0;
    logic ck_t, ck_c, cke, cs_n, act_n, ras_n, cas_n, we_n, addr17, odt;
    logic [16:0] addr, row_addr;
    logic [1:0] ba, bg, cmd_bank, cmd_group;
    logic [9:0] col_addr;
    logic [13:0] mrs_opcode;
    logic [3:0] mrs_select;
    logic cmd_valid, auto_precharge, precharge_all, burst_full, clk_active, ca_buf_en;
    logic ctl_buf_en, out_drv_en, rtt_nom_on, rtt_dqs_upper_on, rtt_dm_upper_on;
    cmd_t cmd;
    pm_t power_mode;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    sdram_cmd_addr_input_decode i_sdram_cmd_addr_input_decode (.*);
    ddr_ctrl_model i_ddr_ctrl_model (.*);
    always #4 sys_clk = ~sys_clk;
    // Hang guard, well above the expected run
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            final_report();
        end
    end
    // Verdict and end of run
    task automatic final_report();
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One link command, then a bounded wait for the decode pulse
    task automatic issue(input logic c, a, input logic [2:0] k, input logic [16:0] ad,
                         input logic [3:0] bb, input cmd_t exp);
        bit seen;
        i_ddr_ctrl_model.send(c, a, k, ad, bb);
        seen = 0;
        for (int i = 0; i < 8 && !seen; i++) begin
            @(posedge sys_clk);
            #1;
            seen = (cmd_valid === 1'b1);
        end
        `CHK(seen, exp != CMD_NONE)
        if (seen) `CHK(cmd, exp)
    endtask
    // New cke/odt levels on a deselected edge, then settle
    task automatic pins(input logic k, o);
        i_ddr_ctrl_model.cke_v = k;
        i_ddr_ctrl_model.odt_v = o;
        i_ddr_ctrl_model.send(1'b1, 1'b1, 3'h7, 17'h0, 4'h0);
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
    // Every other code, a masked one, then activate
    task automatic s_codes();
        logic [3:0] codes [7] = '{CODE_MRS, CODE_REF, CODE_PRE, CODE_RD, CODE_WR, CODE_ZQC, CODE_NOP};
        cmd_t kinds [7] = '{CMD_MRS, CMD_REF, CMD_PRE, CMD_RD, CMD_WR, CMD_ZQC, CMD_NOP};
        for (int i = 0; i < 7; i++) begin
            issue(codes[i][3], 1'b1, codes[i][2:0], 17'h01234, 4'h5, kinds[i]);
        end
        issue(1'b1, 1'b1, CODE_RD[2:0], 17'h0, 4'h0, CMD_NONE);
        issue(1'b0, 1'b0, 3'h5, 17'h02abc, 4'h6, CMD_ACT);
        `CHK({row_addr, cmd_group, cmd_bank}, {17'h16abc, 4'h6})
    endtask
    // Address qualifiers back to back
    task automatic s_fields();
        issue(1'b0, 1'b1, CODE_MRS[2:0], 17'h02a5c, 4'h7, CMD_MRS);
        `CHK({mrs_select, mrs_opcode}, {4'h7, 14'h2a5c})
        issue(1'b0, 1'b1, CODE_RD[2:0], 17'h015a7, 4'h2, CMD_RD);
        `CHK({auto_precharge, burst_full, col_addr}, 12'hda7)
        issue(1'b0, 1'b1, CODE_WR[2:0], 17'h00123, 4'h2, CMD_WR);
        `CHK({cmd_bank, auto_precharge, burst_full, col_addr}, 14'h2123)
        issue(1'b0, 1'b1, CODE_PRE[2:0], 17'h00400, 4'h1, CMD_PRE);
        `CHK(precharge_all, 1'b1)
        issue(1'b0, 1'b1, CODE_PRE[2:0], 17'h0, 4'h1, CMD_PRE);
        `CHK({precharge_all, cmd_bank}, 3'h1)
        x16_mode = 1'b1;
        issue(1'b0, 1'b0, 3'h0, 17'h0, 4'hc, CMD_ACT);
        `CHK(cmd_group, 2'h1)
    endtask
    // Termination by width, and with the enable off
    task automatic s_odt();
        rtt_nom_en = 1'b1;
        pins(1'b1, 1'b1);
        `CHK({rtt_nom_on, rtt_dqs_upper_on, rtt_dm_upper_on}, 3'h7)
        pins(1'b1, 1'b0);
        x16_mode = 1'b0;
        pins(1'b1, 1'b1);
        `CHK({rtt_nom_on, rtt_dqs_upper_on, rtt_dm_upper_on}, 3'h4)
        pins(1'b1, 1'b0);
        rtt_nom_en = 1'b0;
        pins(1'b1, 1'b1);
        `CHK(rtt_nom_on, 1'b0)
        pins(1'b1, 1'b0);
    endtask
    // Precharge and active power-down, self refresh and its exit
    task automatic s_power();
        issue(1'b0, 1'b1, CODE_PRE[2:0], 17'h00400, 4'h0, CMD_PRE);
        pins(1'b0, 1'b0);
        `CHK({power_mode, clk_active, ctl_buf_en, ca_buf_en, out_drv_en}, {PM_PPD, 4'hc})
        issue(1'b0, 1'b1, CODE_RD[2:0], 17'h0, 4'h0, CMD_NONE);
        pins(1'b1, 1'b0);
        `CHK({power_mode, ca_buf_en, out_drv_en}, {PM_RUN, 2'h3})
        issue(1'b0, 1'b0, 3'h0, 17'h0, 4'h3, CMD_ACT);
        pins(1'b0, 1'b0);
        `CHK(power_mode, PM_APD)
        pins(1'b1, 1'b0);
        issue(1'b0, 1'b1, CODE_PRE[2:0], 17'h00400, 4'h0, CMD_PRE);
        self_refresh_req = 1'b1;
        pins(1'b0, 1'b0);
        `CHK({power_mode, clk_active, ctl_buf_en, ca_buf_en, out_drv_en}, {PM_SR, 4'h0})
        i_ddr_ctrl_model.wake();
        repeat (8) @(posedge sys_clk);
        #1;
        `CHK(power_mode, PM_RUN)
        self_refresh_req = 1'b0;
        i_ddr_ctrl_model.run = 1'b1;
        issue(1'b0, 1'b1, CODE_RD[2:0], 17'h0, 4'h0, CMD_RD);
    endtask
    // Reset, then the scenarios in turn
    initial begin
        repeat (4) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK({power_mode, ca_buf_en, out_drv_en}, {PM_RUN, 2'h3})
        s_codes();
        s_fields();
        s_odt();
        s_power();
        final_report();
    end
endmodule
`default_nettype wire
